// >>> dal_pkg.sv
package dal_pkg;
	// ************************************************************
	// spindle states and timing
	// ************************************************************
	typedef enum logic [1:0] {
		DAL_SPIN_DOWN  = 2'h0,
		DAL_SPIN_UP    = 2'h1,
		DAL_SPIN_MOVE  = 2'h2,
		DAL_SPIN_NONE  = 2'h3
	} dal_spin_t;

	localparam int unsigned DAL_CLK_HZ         = 125000000;
	localparam int unsigned DAL_BLINK_HALF_MS  = 500;
	localparam int unsigned DAL_BLINK_HALF_CYC = (DAL_CLK_HZ / 1000) * DAL_BLINK_HALF_MS;
	localparam logic        DAL_SENSE_RESET    = 1'b0;
	localparam logic        DAL_LIT_RESET      = 1'b0;
endpackage : dal_pkg

// >>> dal_tick_if.sv
`timescale 1ns/10ps
`default_nettype none
interface dal_tick_if;
	logic run;
	logic tick;
	modport timer (input run, output tick);
	modport user  (output run, input tick);
endinterface : dal_tick_if
`default_nettype wire

// >>> dal_blink_timer.sv
`timescale 1ns/10ps
`default_nettype none
module dal_blink_timer #(
	parameter int unsigned HALF_CYC = 62500000
) (
	input  wire logic  clk_in,
	input  wire logic  rst_n_in,
	dal_tick_if.timer  tick_if
);
	localparam int unsigned CW = $clog2(HALF_CYC + 1);
	logic [CW-1:0] count_reg;

	initial begin
		if (HALF_CYC < 2) begin
			$error("HALF_CYC must be at least 2");
		end
	end

	// counter clears while idle so each blink phase starts full length
	always_ff @(posedge clk_in) begin
		if (!rst_n_in || !tick_if.run) begin
			count_reg <= '0;
			tick_if.tick <= 1'b0;
		end else if (count_reg == CW'(HALF_CYC - 1)) begin
			count_reg <= '0;
			tick_if.tick <= 1'b1;
		end else begin
			count_reg <= count_reg + CW'(1);
			tick_if.tick <= 1'b0;
		end
	end
endmodule : dal_blink_timer
`default_nettype wire

// >>> dal_led_driver.sv
`timescale 1ns/10ps
`default_nettype none
module dal_led_driver
	import dal_pkg::*;
#(
	parameter int unsigned BLINK_HALF_CYC = DAL_BLINK_HALF_CYC
) (
	input  wire logic       clk_in,
	input  wire logic       rst_n_in,
	input  wire dal_spin_t  spin_state_in,
	input  wire logic       spin_valid_in,
	input  wire logic       cmd_accept_in,
	input  wire logic       cmd_done_in,
	input  wire logic       format_active_in,
	input  wire logic       cylinder_step_in,
	input  wire logic       sense_write_in,
	input  wire logic       sense_value_in,
	output logic            indicator_drive_out,
	output logic            indicator_drive_oe_out,
	output logic            busy_out
);
	// ************************************************************
	// state
	// ************************************************************
	dal_spin_t spin_reg;
	logic      known_reg;
	logic      busy_reg;
	logic      sense_reg;
	logic      blink_reg;
	logic      fmt_reg;
	logic      lit_next;
	dal_tick_if tick_bus ();

	// ************************************************************
	// elaboration checks
	// ************************************************************
	initial begin
		if (BLINK_HALF_CYC < 2) begin
			$error("BLINK_HALF_CYC too small");
		end
		if (BLINK_HALF_CYC > 32'h7fffffff) begin
			$error("BLINK_HALF_CYC too large");
		end
	end

	// ************************************************************
	// blink timing
	// ************************************************************
	// the timer only counts while a spin transition is reported
	dal_blink_timer #(
		.HALF_CYC (BLINK_HALF_CYC)
	) u_timer (
		.clk_in   (clk_in),
		.rst_n_in (rst_n_in),
		.tick_if  (tick_bus.timer)
	);

	assign tick_bus.run = known_reg && (spin_reg == DAL_SPIN_MOVE);

	// blink starts lit on entry to a spin transition
	// limitation: every new transition restarts the phase lit
	always_ff @(posedge clk_in) begin
		if (!rst_n_in || !tick_bus.run) begin
			blink_reg <= 1'b1;
		end else if (tick_bus.tick) begin
			blink_reg <= ~blink_reg;
		end
	end

	// ************************************************************
	// spindle report
	// ************************************************************
	// a repeat of the same report changes nothing
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			spin_reg  <= DAL_SPIN_NONE;
			known_reg <= 1'b0;
		end else if (spin_valid_in) begin
			spin_reg  <= spin_state_in;
			known_reg <= 1'b1;
		end
	end

	// ************************************************************
	// command activity
	// ************************************************************
	// accept wins over a completion in the same cycle
	// a completion with nothing pending is harmless
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			busy_reg <= 1'b0;
		end else if (cmd_accept_in) begin
			busy_reg <= 1'b1;
		end else if (cmd_done_in) begin
			busy_reg <= 1'b0;
		end
	end

	// ************************************************************
	// meaning bit
	// ************************************************************
	// strobe only; no register bus reaches this bit
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			sense_reg <= DAL_SENSE_RESET;
		end else if (sense_write_in) begin
			sense_reg <= sense_value_in;
		end
	end

	// ************************************************************
	// format toggling
	// ************************************************************
	// phase follows the lit state one cycle late while no format runs, so the
	// start of a format flips the indicator by itself only when it changed on the edge before
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			fmt_reg <= DAL_LIT_RESET;
		end else if (!format_active_in) begin
			fmt_reg <= indicator_drive_oe_out;
		end else if (cylinder_step_in) begin
			fmt_reg <= ~fmt_reg;
		end
	end

	// ************************************************************
	// indicator selection
	// ************************************************************
	// one-hot source keeps the priority order readable
	typedef enum logic [4:0] {
		DAL_SRC_OFF   = 5'h01,
		DAL_SRC_BLINK = 5'h02,
		DAL_SRC_FMT   = 5'h04,
		DAL_SRC_UP    = 5'h08,
		DAL_SRC_DOWN  = 5'h10
	} dal_src_t;
	dal_src_t src_sel;

	// format before activity: each cylinder change must show
	always_comb begin
		src_sel = DAL_SRC_OFF;
		if (!known_reg) begin
			src_sel = DAL_SRC_OFF;
		end else if (spin_reg == DAL_SPIN_MOVE) begin
			src_sel = DAL_SRC_BLINK;
		end else if (format_active_in) begin
			src_sel = DAL_SRC_FMT;
		end else if (spin_reg == DAL_SPIN_UP) begin
			src_sel = DAL_SRC_UP;
		end else if (spin_reg == DAL_SPIN_DOWN) begin
			src_sel = DAL_SRC_DOWN;
		end
	end

	// an unknown spin report falls through to off unless a format is active
	always_comb begin
		lit_next = DAL_LIT_RESET;
		case (src_sel)
			DAL_SRC_OFF: begin
				lit_next = DAL_LIT_RESET;
			end
			DAL_SRC_BLINK: begin
				lit_next = blink_reg;
			end
			DAL_SRC_FMT: begin
				lit_next = cylinder_step_in ? ~fmt_reg : fmt_reg;
			end
			DAL_SRC_UP: begin
				lit_next = busy_reg ? sense_reg : ~sense_reg;
			end
			DAL_SRC_DOWN: begin
				lit_next = busy_reg;
			end
			default: begin
				lit_next = DAL_LIT_RESET;
			end
		endcase
	end

	// ************************************************************
	// pin registers
	// ************************************************************
	// open drain: the enable lights the led, data never goes high,
	// so a released pin is left to the external pull-up
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			indicator_drive_oe_out <= DAL_LIT_RESET;
		end else begin
			indicator_drive_oe_out <= lit_next;
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			indicator_drive_out <= 1'b0;
		end else begin
			indicator_drive_out <= 1'b0;
		end
	end

	// busy is registered again so it lines up with the pin
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			busy_out <= 1'b0;
		end else begin
			busy_out <= busy_reg;
		end
	end
endmodule : dal_led_driver
`default_nettype wire

// >>> dal_led_sva.sv
`timescale 1ns/10ps
`default_nettype none
// ****
// indicator checks
// ****
module dal_led_sva
	import dal_pkg::*;
#(
	parameter int unsigned BLINK_HALF_CYC = 8
) (
	input wire logic      clk_in,
	input wire logic      rst_n_in,
	input wire dal_spin_t spin_state_in,
	input wire logic      spin_valid_in,
	input wire logic      cmd_accept_in,
	input wire logic      cmd_done_in,
	input wire logic      format_active_in,
	input wire logic      cylinder_step_in,
	input wire logic      sense_write_in,
	input wire logic      sense_value_in,
	input wire logic      indicator_drive_out,
	input wire logic      indicator_drive_oe_out,
	input wire logic      busy_out
);
	localparam int H = BLINK_HALF_CYC;
	logic sns_reg;
	wire  oe = indicator_drive_oe_out;
	wire  q  = spin_valid_in & ~format_active_in & ~sense_write_in;
	wire  mv = spin_valid_in & (spin_state_in == DAL_SPIN_MOVE);
	wire  fu = spin_valid_in & (spin_state_in == DAL_SPIN_UP) & format_active_in;
	always_ff @(posedge clk_in) begin
		sns_reg <= !rst_n_in ? 1'b0 : (sense_write_in ? sense_value_in : sns_reg);
	end
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	a_drive_low: assert property (indicator_drive_out == 1'b0)
		else $error("drive not low");
	a_down_mode: assert property ((q && spin_state_in == DAL_SPIN_DOWN)[*3] |-> oe == busy_out)
		else $error("spun down state wrong");
	a_up_mode: assert property ((q && spin_state_in == DAL_SPIN_UP)[*3] |-> oe == !(busy_out ^ sns_reg))
		else $error("spun up state wrong");
	a_unknown_off: assert property ((spin_valid_in && spin_state_in == DAL_SPIN_NONE)[*3] |-> !oe)
		else $error("lit while unknown");
	a_blink_half: assert property (mv[*5] ##0 $changed(oe) |-> ##[H:H] ($changed(oe) || !mv))
		else $error("blink half period wrong");
	a_step_flip: assert property (fu[*3] ##0 cylinder_step_in |-> ##[1:2] $changed(oe))
		else $error("no toggle on step");
	a_fmt_hold: assert property ((fu && !cylinder_step_in)[*3] |-> $stable(oe))
		else $error("format state moved");
	a_busy_set: assert property (cmd_accept_in |-> ##2 busy_out)
		else $error("busy not set");
	a_busy_clr: assert property ((cmd_done_in && !cmd_accept_in) ##1 !cmd_accept_in |=> !busy_out)
		else $error("busy not cleared");
	c_blink: cover property (mv ##1 $changed(oe));
	c_step: cover property (fu && cylinder_step_in);
	c_done: cover property (cmd_done_in);
endmodule : dal_led_sva
bind dal_led_driver dal_led_sva #(
	.BLINK_HALF_CYC (BLINK_HALF_CYC)
) u_sva (
	.clk_in                 (clk_in),
	.rst_n_in               (rst_n_in),
	.spin_state_in          (spin_state_in),
	.spin_valid_in          (spin_valid_in),
	.cmd_accept_in          (cmd_accept_in),
	.cmd_done_in            (cmd_done_in),
	.format_active_in       (format_active_in),
	.cylinder_step_in       (cylinder_step_in),
	.sense_write_in         (sense_write_in),
	.sense_value_in         (sense_value_in),
	.indicator_drive_out    (indicator_drive_out),
	.indicator_drive_oe_out (indicator_drive_oe_out),
	.busy_out               (busy_out)
);
`default_nettype wire

// >>> dal_led_model.sv
`timescale 1ns/10ps
`default_nettype none
// ****
// led to 3.3 v through resistor
// ****
module dal_led_model (
	input  wire logic drive_in,
	input  wire logic oe_in,
	output logic      pin_out,
	output logic      lit_out
);
	// resistor pulls the released pin high
	assign pin_out = oe_in ? drive_in : 1'b1;
	assign lit_out = !pin_out;
endmodule : dal_led_model
`default_nettype wire

// >>> dal_led_driver_tb.sv
`timescale 1ns/10ps
`default_nettype none
// ****
// bench
// ****
module dal_led_driver_tb import dal_pkg::*; ;
	logic      clk_in = 0, rst_n_in = 0, spin_valid_in = 0, cmd_accept_in = 0, cmd_done_in = 0;
	logic      format_active_in = 0, cylinder_step_in = 0, sense_write_in = 0, sense_value_in = 0;
	dal_spin_t spin_state_in = DAL_SPIN_NONE;
	logic      drv, oe, busy, pin, lit, v;
	int        n_mismatch = 0, num_checks = 0, n;
	always #4 clk_in = ~clk_in;
	dal_led_driver #(.BLINK_HALF_CYC(8)) dut (.clk_in(clk_in), .rst_n_in(rst_n_in),
		.spin_state_in(spin_state_in), .spin_valid_in(spin_valid_in),
		.cmd_accept_in(cmd_accept_in), .cmd_done_in(cmd_done_in),
		.format_active_in(format_active_in), .cylinder_step_in(cylinder_step_in),
		.sense_write_in(sense_write_in), .sense_value_in(sense_value_in),
		.indicator_drive_out(drv), .indicator_drive_oe_out(oe), .busy_out(busy));
	dal_led_model lm (.drive_in(drv), .oe_in(oe), .pin_out(pin), .lit_out(lit));
	task automatic tick(input int k);
		repeat (k) @(posedge clk_in);
	endtask : tick
	task automatic chk(input string nm, input logic e, input logic g);
		num_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("[ERR] %s exp %b got %b", nm, e, g);
		end
	endtask : chk
	task automatic cmd(input logic a);
		@(posedge clk_in);
		cmd_accept_in <= a;
		cmd_done_in <= !a;
		@(posedge clk_in);
		cmd_accept_in <= 1'b0;
		cmd_done_in <= 1'b0;
	endtask : cmd
	task automatic step;
		@(posedge clk_in);
		cylinder_step_in <= 1'b1;
		@(posedge clk_in);
		cylinder_step_in <= 1'b0;
		tick(3);
	endtask : step
	task automatic t_start;
		cmd(1'b1);
		tick(4);
		chk("lit", 1'b0, lit);
		spin_valid_in <= 1'b1;
		tick(4);
		chk("lit", 1'b0, lit);
	endtask : t_start
	task automatic t_table;
		for (int s = 0; s < 2; s++) begin
			@(posedge clk_in);
			sense_write_in <= 1'b1;
			sense_value_in <= s[0];
			@(posedge clk_in);
			sense_write_in <= 1'b0;
			for (int k = 0; k < 4; k++) begin
				spin_state_in <= k[1] ? DAL_SPIN_UP : DAL_SPIN_DOWN;
				cmd(k[0]);
				tick(3);
				chk("busy", k[0], busy);
				chk("lit", k[1] ? !(k[0] ^ s[0]) : k[0], lit);
			end
		end
	endtask : t_table
	task automatic t_blink;
		spin_state_in <= DAL_SPIN_MOVE;
		tick(30);
		for (int i = 0; i < 3; i++) begin
			v = lit;
			n = 0;
			while (lit === v && n < 40) begin
				tick(1);
				n++;
			end
			if (i > 0) chk("half", 1'b1, n == 8);
		end
	endtask : t_blink
	task automatic t_format;
		spin_state_in <= DAL_SPIN_UP;
		tick(6);
		v = lit;
		format_active_in <= 1'b1;
		tick(6);
		chk("fmt_start", v, lit);
		step;
		chk("fmt", !v, lit);
		cmd(1'b0);
		tick(4);
		chk("fmt", !v, lit);
		step;
		chk("fmt", v, lit);
	endtask : t_format
	task automatic t_reset;
		cmd(1'b1);
		tick(3);
		rst_n_in <= 1'b0;
		format_active_in <= 1'b0;
		tick(3);
		chk("lit", 1'b0, lit);
		chk("busy", 1'b0, busy);
		rst_n_in <= 1'b1;
		tick(1);
		chk("lit", 1'b0, lit);
		tick(4);
		chk("lit", 1'b1, lit);
	endtask : t_reset
	task automatic report_and_stop;
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : report_and_stop
	initial begin
		tick(3000);
		n_mismatch++;
		report_and_stop;
	end
	initial begin
		tick(20);
		rst_n_in <= 1'b1;
		t_start;
		t_table;
		t_blink;
		t_format;
		t_reset;
		report_and_stop;
	end
endmodule : dal_led_driver_tb
`default_nettype wire
